//--- design/adcsq_top.sv
// Converter sequence control with AHB-Lite register slave
`timescale 1ns/100ps
module adcsq_top
    import adcsq_pkg::*;
#(
    parameter bit SIX_INPUTS = 1'b1
)
(
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic RC_CLOCK_TICK_IN,
    input wire logic PIN_TRIGGER_IN,
    input wire logic TIMER_TRIGGER_IN,
    input wire logic PWM_TRIGGER_IN,
    input wire logic [5:0] SCAN_SELECT_IN,
    output logic SAMPLING_OUT,
    output logic CONVERTING_OUT,
    output logic [2:0] CH0_POS_INPUT_OUT,
    output logic CH0_NEG_INPUT1_OUT,
    output logic [2:0] CH1_POS_INPUT_OUT,
    output logic [2:0] CH2_POS_INPUT_OUT,
    output logic [2:0] CH3_POS_INPUT_OUT,
    output logic AUX_NEG_GROUND_OUT,
    output logic REF_POS_SUPPLY_OUT,
    output logic REF_NEG_GROUND_OUT,
    output logic [3:0] ACTIVE_CHANNELS_OUT,
    output logic [3:0] BUFFER_WRITE_INDEX_OUT,
    output logic RESULT_WRITE_OUT,
    output logic CONV_INTERRUPT_OUT
);
    logic [15:0] con1;
    logic [15:0] con2;
    logic [15:0] con3;
    logic [15:0] chs123;
    logic [15:0] chs0;
    logic done;
    logic sample;
    logic buf_half;
    logic use_b;
    logic [3:0] seq_count;
    logic [3:0] wr_index;
    logic [2:0] scan_ptr;
    logic [7:0] div_count;
    logic [4:0] tad_count;
    logic [3:0] conv_count;
    logic [2:0] ch_left;
    adcsq_state_t state;
    logic dp_write;
    logic dp_read;
    logic [7:0] dp_addr;
    logic [15:0] wdata;
    logic tad_tick;
    logic module_on;
    logic [2:0] trig;
    logic trigger_hit;
    logic conv_start;
    logic conv_end;
    logic last_seq;
    logic [2:0] n_channels;
    logic [2:0] next_scan;
    logic [2:0] cur_scan;
    logic [4:0] pos_code;

    // Maps a five-bit main positive code to an input index
    function automatic logic [2:0] adcsq_pos_map(input logic [4:0] code, input logic six);
        logic [2:0] result;
        result = ADCSQ_INPUT_NONE;
        if (code == ADCSQ_SENSOR_CODE)
        begin
            result = ADCSQ_INPUT_SENSOR;
        end
        else if (code <= 5'h03 || (six && code <= 5'h05))
        begin
            result = code[2:0];
        end
        return result;
    endfunction

    // First selected scan input at ptr plus skip or later; none selected keeps ptr
    function automatic logic [2:0] adcsq_scan_pick(input logic [2:0] ptr, input logic [5:0] sel, input int skip);
        logic [2:0] result;
        result = ptr;
        for (int i = 5; i >= skip; i--)
        begin
            if (sel[(int'(ptr) + i) % 6])
            begin
                result = 3'((int'(ptr) + i) % 6);
            end
        end
        return result;
    endfunction

    assign module_on = con1[ADCSQ_CON1_ON];
    assign trig = con1[ADCSQ_CON1_TRIG_LO +: 3];
    assign wdata = HWDATA_IN[15:0];
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;

    // Address phase capture; zero wait states
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 8'h00;
        end
        else if (HREADY_IN)
        begin
            dp_write <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
            dp_read <= HSEL_IN && HTRANS_IN[1] && !HWRITE_IN;
            dp_addr <= HADDR_IN[7:0];
        end
    end

    // Read data; unmapped offsets read zero
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            HRDATA_OUT <= 32'h00000000;
        end
        else if (HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN)
        begin
            if (HADDR_IN[7:0] == ADCSQ_OFF_CON1)
            begin
                HRDATA_OUT <= {16'h0000, con1[15:2], sample, done};
            end
            else if (HADDR_IN[7:0] == ADCSQ_OFF_CON2)
            begin
                HRDATA_OUT <= {16'h0000, con2[15:8], buf_half && con2[ADCSQ_CON2_SPLIT_BUFFER_MODE], con2[6:0]};
            end
            else if (HADDR_IN[7:0] == ADCSQ_OFF_CON3)
            begin
                HRDATA_OUT <= {16'h0000, con3};
            end
            else if (HADDR_IN[7:0] == ADCSQ_OFF_CHS123)
            begin
                HRDATA_OUT <= {16'h0000, chs123};
            end
            else if (HADDR_IN[7:0] == ADCSQ_OFF_CHS0)
            begin
                HRDATA_OUT <= {16'h0000, chs0};
            end
            else if (HADDR_IN[7:0] == ADCSQ_OFF_STATUS)
            begin
                HRDATA_OUT <= {25'h0, state, wr_index};
            end
            else
            begin
                HRDATA_OUT <= 32'h00000000;
            end
        end
    end

    // Plain control registers; reserved bits kept zero
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            con1 <= ADCSQ_REG_RESET;
            con2 <= ADCSQ_REG_RESET;
            con3 <= ADCSQ_REG_RESET;
            chs123 <= ADCSQ_REG_RESET;
            chs0 <= ADCSQ_REG_RESET;
        end
        else if (dp_write)
        begin
            if (dp_addr == ADCSQ_OFF_CON1)
            begin
                con1 <= wdata & ADCSQ_CON1_MASK;
            end
            else if (dp_addr == ADCSQ_OFF_CON2)
            begin
                con2 <= wdata & ADCSQ_CON2_MASK & 16'hFF7F;
            end
            else if (dp_addr == ADCSQ_OFF_CON3)
            begin
                con3 <= wdata & ADCSQ_CON3_MASK;
            end
            else if (dp_addr == ADCSQ_OFF_CHS123)
            begin
                chs123 <= wdata & ADCSQ_CHS123_MASK;
            end
            else if (dp_addr == ADCSQ_OFF_CHS0)
            begin
                chs0 <= wdata & ADCSQ_CHS0_MASK;
            end
        end
    end

    // Conversion clock tick: RC tick or divided system clock
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN || !module_on)
        begin
            div_count <= 8'h00;
        end
        else if (con3[ADCSQ_CON3_RC])
        begin
            div_count <= 8'h00;
        end
        else if (div_count >= con3[7:0] || div_count >= ADCSQ_DIV_MAX)
        begin
            div_count <= 8'h00;
        end
        else
        begin
            div_count <= div_count + 8'h01;
        end
    end
    assign tad_tick = con3[ADCSQ_CON3_RC] ? RC_CLOCK_TICK_IN
        : (div_count >= con3[7:0] || div_count >= ADCSQ_DIV_MAX);

    always_comb
    begin
        trigger_hit = 1'b0;
        case (trig)
            ADCSQ_TRIG_PIN: trigger_hit = PIN_TRIGGER_IN;
            ADCSQ_TRIG_TIMER: trigger_hit = TIMER_TRIGGER_IN;
            ADCSQ_TRIG_PWM: trigger_hit = PWM_TRIGGER_IN;
            ADCSQ_TRIG_AUTO: trigger_hit = tad_tick && tad_count >= con3[ADCSQ_CON3_AUTO_SAMPLE_TIME_LO +: 5];
            default: trigger_hit = 1'b0;
        endcase
    end

    assign n_channels = con2[ADCSQ_CON2_CHANNEL_COUNT_SELECT_LO + 1] ? 3'h4 : (con2[ADCSQ_CON2_CHANNEL_COUNT_SELECT_LO] ? 3'h2 : 3'h1);
    assign conv_start = state == ADCSQ_SAMPLE && (trig == ADCSQ_TRIG_SW ? !sample : trigger_hit);
    assign conv_end = state == ADCSQ_CONVERT && tad_tick && conv_count == ADCSQ_CONV_TAD && ch_left == 3'h1;
    assign last_seq = seq_count == con2[ADCSQ_CON2_SEQUENCES_PER_INTERRUPT_LO +: 4];

    // Sequence state machine
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN || !module_on)
        begin
            state <= ADCSQ_IDLE;
            tad_count <= 5'h00;
            conv_count <= 4'h0;
            ch_left <= 3'h0;
        end
        else
        begin
            case (state)
                ADCSQ_IDLE:
                begin
                    tad_count <= 5'h00;
                    if (sample)
                    begin
                        state <= ADCSQ_SAMPLE;
                    end
                end
                ADCSQ_SAMPLE:
                begin
                    if (conv_start)
                    begin
                        state <= ADCSQ_CONVERT;
                        conv_count <= 4'h0;
                        ch_left <= n_channels;
                    end
                    else if (tad_tick && tad_count != 5'h1F)
                    begin
                        tad_count <= tad_count + 5'h01;
                    end
                end
                ADCSQ_CONVERT:
                begin
                    tad_count <= 5'h00;
                    if (tad_tick)
                    begin
                        if (conv_count != ADCSQ_CONV_TAD)
                        begin
                            conv_count <= conv_count + 4'h1;
                        end
                        else if (ch_left == 3'h1)
                        begin
                            state <= ADCSQ_IDLE;
                        end
                        else
                        begin
                            conv_count <= 4'h0;
                            ch_left <= ch_left - 3'h1;
                        end
                    end
                end
                default: state <= ADCSQ_IDLE;
            endcase
        end
    end

    // Sample enable: software set, autostart set, hardware clear
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN || !module_on)
        begin
            sample <= 1'b0;
        end
        else if (conv_start && trig != ADCSQ_TRIG_SW)
        begin
            sample <= 1'b0;
        end
        else if (conv_end && con1[ADCSQ_CON1_AUTOSTART])
        begin
            sample <= 1'b1;
        end
        else if (dp_write && dp_addr == ADCSQ_OFF_CON1)
        begin
            sample <= wdata[ADCSQ_CON1_SAMPLE];
        end
    end

    // Done flag: set wins over a same-cycle clear
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            done <= 1'b0;
        end
        else if (conv_end)
        begin
            done <= 1'b1;
        end
        else if (conv_start)
        begin
            done <= 1'b0;
        end
        else if (dp_write && dp_addr == ADCSQ_OFF_CON1 && !wdata[ADCSQ_CON1_DONE])
        begin
            done <= 1'b0;
        end
    end

    // Sequence counter, buffer halves, A/B alternation, scan pointer
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN || !module_on)
        begin
            seq_count <= 4'h0;
            wr_index <= 4'h0;
            buf_half <= 1'b0;
            use_b <= 1'b0;
            scan_ptr <= 3'h0;
        end
        else
        begin
            if (conv_end)
            begin
                use_b <= con2[ADCSQ_CON2_ALTERNATE_SAMPLE_MODE] && !use_b;
                if (con2[ADCSQ_CON2_SCAN] && !use_b)
                begin
                    scan_ptr <= next_scan;
                end
                if (last_seq)
                begin
                    seq_count <= 4'h0;
                    buf_half <= con2[ADCSQ_CON2_SPLIT_BUFFER_MODE] && !buf_half;
                    wr_index <= (con2[ADCSQ_CON2_SPLIT_BUFFER_MODE] && !buf_half) ? ADCSQ_BUF_HALF : 4'h0;
                end
                else
                begin
                    seq_count <= seq_count + 4'h1;
                end
            end
            if (RESULT_WRITE_OUT && !(conv_end && last_seq))
            begin
                wr_index <= wr_index + 4'h1;
            end
        end
    end

    // Pointer restarts at zero; an unselected start skips ahead so only selected inputs are sampled, unless none is selected and the pointer input is used
    assign cur_scan = adcsq_scan_pick(scan_ptr, SCAN_SELECT_IN, 0);
    assign next_scan = adcsq_scan_pick(cur_scan, SCAN_SELECT_IN, 1);

    assign pos_code = (con2[ADCSQ_CON2_SCAN] && !use_b) ? {2'b00, cur_scan} : (use_b ? chs0[12:8] : chs0[4:0]);
    assign RESULT_WRITE_OUT = state == ADCSQ_CONVERT && tad_tick && conv_count == ADCSQ_CONV_TAD;

    // Registered mux and status outputs
    always_ff @(posedge MCLK_IN)
    begin
        if (RST_IN)
        begin
            CH0_POS_INPUT_OUT <= ADCSQ_INPUT_NONE;
            CH0_NEG_INPUT1_OUT <= 1'b0;
            CH1_POS_INPUT_OUT <= ADCSQ_INPUT_NONE;
            CH2_POS_INPUT_OUT <= ADCSQ_INPUT_NONE;
            CH3_POS_INPUT_OUT <= ADCSQ_INPUT_NONE;
            AUX_NEG_GROUND_OUT <= 1'b1;
            ACTIVE_CHANNELS_OUT <= 4'h0;
            CONV_INTERRUPT_OUT <= 1'b0;
        end
        else
        begin
            CH0_POS_INPUT_OUT <= adcsq_pos_map(pos_code, SIX_INPUTS);
            CH0_NEG_INPUT1_OUT <= use_b ? chs0[15] : chs0[7];
            if (use_b ? chs123[8] : chs123[0])
            begin
                CH1_POS_INPUT_OUT <= 3'h3;
                CH2_POS_INPUT_OUT <= SIX_INPUTS ? 3'h4 : ADCSQ_INPUT_NONE;
                CH3_POS_INPUT_OUT <= SIX_INPUTS ? 3'h5 : ADCSQ_INPUT_NONE;
            end
            else
            begin
                CH1_POS_INPUT_OUT <= 3'h0;
                CH2_POS_INPUT_OUT <= 3'h1;
                CH3_POS_INPUT_OUT <= 3'h2;
            end
            AUX_NEG_GROUND_OUT <= !(use_b ? chs123[10] : chs123[2]);
            ACTIVE_CHANNELS_OUT <= module_on ? (n_channels[2] ? 4'hF : (n_channels[1] ? 4'h3 : 4'h1)) : 4'h0;
            CONV_INTERRUPT_OUT <= conv_end && last_seq;
        end
    end

    assign REF_POS_SUPPLY_OUT = 1'b1;
    assign REF_NEG_GROUND_OUT = 1'b1;
    assign SAMPLING_OUT = state == ADCSQ_SAMPLE;
    assign CONVERTING_OUT = state == ADCSQ_CONVERT;
    assign BUFFER_WRITE_INDEX_OUT = wr_index;
endmodule

//--- design/adcsq_pkg.sv
// Package for converter sequence control: offsets, fields, reset values, states
// Function
// - Hardware sets done flag when conversion ends
// - Software clears done only; conversion undisturbed
// - Done flag cleared when new conversion starts
// - References always analog supply and ground
// - Scan enable steps channel 0 positive input
// - Channel count selects one, two, four channels
// - Buffer half status shows half being filled
// - Interrupt every N plus one sequences
// - Split mode alternates buffer halves per interrupt
// - Alternate mode toggles Sample A and B
// - Clock source bit picks RC or system
// - Auto sample time counts conversion clocks
// - Auto sample time used only with counter trigger
// - Divider gives D plus one cycles period, D capped at 63
// - Divider ignored when RC clock selected
// - Aux negative inputs ground for codes 0x
// - Aux positive select zero routes inputs 0-2
// - Small variant select one: input 3 only
// - Main negative bit picks input 1 or ground
// - Main positive code picks input or sensor
// - Trigger source field picks conversion start event
// - Non-software trigger clears sample enable in hardware
package adcsq_pkg;
    localparam logic [7:0] ADCSQ_OFF_CON1 = 8'h00;
    localparam logic [7:0] ADCSQ_OFF_CON2 = 8'h04;
    localparam logic [7:0] ADCSQ_OFF_CON3 = 8'h08;
    localparam logic [7:0] ADCSQ_OFF_CHS123 = 8'h0C;
    localparam logic [7:0] ADCSQ_OFF_CHS0 = 8'h10;
    localparam logic [7:0] ADCSQ_OFF_STATUS = 8'h14;
    localparam int ADCSQ_CON1_ON = 15;
    localparam int ADCSQ_CON1_TRIG_LO = 5;
    localparam int ADCSQ_CON1_AUTOSTART = 2;
    localparam int ADCSQ_CON1_SAMPLE = 1;
    localparam int ADCSQ_CON1_DONE = 0;
    localparam int ADCSQ_CON2_SCAN = 10;
    localparam int ADCSQ_CON2_CHANNEL_COUNT_SELECT_LO = 8;
    localparam int ADCSQ_CON2_BUFFER_HALF_STATUS = 7;
    localparam int ADCSQ_CON2_SEQUENCES_PER_INTERRUPT_LO = 2;
    localparam int ADCSQ_CON2_SPLIT_BUFFER_MODE = 1;
    localparam int ADCSQ_CON2_ALTERNATE_SAMPLE_MODE = 0;
    localparam int ADCSQ_CON3_RC = 15;
    localparam int ADCSQ_CON3_AUTO_SAMPLE_TIME_LO = 8;
    localparam logic [15:0] ADCSQ_CON1_MASK = 16'hA0EF;
    localparam logic [15:0] ADCSQ_CON2_MASK = 16'hE73F;
    localparam logic [15:0] ADCSQ_CON3_MASK = 16'h9FFF;
    localparam logic [15:0] ADCSQ_CHS123_MASK = 16'h0707;
    localparam logic [15:0] ADCSQ_CHS0_MASK = 16'h9F9F;
    localparam logic [15:0] ADCSQ_REG_RESET = 16'h0000;
    localparam logic [2:0] ADCSQ_TRIG_SW = 3'h0;
    localparam logic [2:0] ADCSQ_TRIG_PIN = 3'h1;
    localparam logic [2:0] ADCSQ_TRIG_TIMER = 3'h2;
    localparam logic [2:0] ADCSQ_TRIG_PWM = 3'h3;
    localparam logic [2:0] ADCSQ_TRIG_AUTO = 3'h7;
    localparam logic [7:0] ADCSQ_DIV_MAX = 8'h3F;
    localparam logic [4:0] ADCSQ_SENSOR_CODE = 5'h0D;
    localparam logic [2:0] ADCSQ_INPUT_NONE = 3'h7;
    localparam logic [2:0] ADCSQ_INPUT_SENSOR = 3'h6;
    localparam logic [3:0] ADCSQ_CONV_TAD = 4'hC;
    localparam logic [3:0] ADCSQ_BUF_HALF = 4'h8;
    typedef enum logic [2:0]
    {
        ADCSQ_IDLE = 3'b001,
        ADCSQ_SAMPLE = 3'b010,
        ADCSQ_CONVERT = 3'b100
    } adcsq_state_t;
endpackage

//--- tb/adcsq_properties.sv
// Port checker for converter sequence control
`timescale 1ns/100ps
module adcsq_properties
#(
    parameter bit SIX_INPUTS = 1'b1
)
(
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic SAMPLING_OUT,
    input wire logic CONVERTING_OUT,
    input wire logic [2:0] CH1_POS_INPUT_OUT,
    input wire logic [2:0] CH2_POS_INPUT_OUT,
    input wire logic [2:0] CH3_POS_INPUT_OUT,
    input wire logic AUX_NEG_GROUND_OUT,
    input wire logic REF_POS_SUPPLY_OUT,
    input wire logic REF_NEG_GROUND_OUT,
    input wire logic [3:0] ACTIVE_CHANNELS_OUT,
    input wire logic RESULT_WRITE_OUT,
    input wire logic CONV_INTERRUPT_OUT
);
    default clocking @(posedge MCLK_IN);
    endclocking
    default disable iff (RST_IN);
    a_ref_fixed: assert property (REF_POS_SUPPLY_OUT && REF_NEG_GROUND_OUT)
        else $error("reference select not supply and ground");
    a_state_excl: assert property (!(SAMPLING_OUT && CONVERTING_OUT))
        else $error("sampling and converting together");
    a_conv_from_sample: assert property ($rose(CONVERTING_OUT) |-> $past(SAMPLING_OUT))
        else $error("conversion began without sampling");
    a_irq_single: assert property (CONV_INTERRUPT_OUT |=> !CONV_INTERRUPT_OUT)
        else $error("interrupt longer than one cycle");
    a_irq_cause: assert property (CONV_INTERRUPT_OUT |-> $past(CONVERTING_OUT))
        else $error("interrupt without a finished conversion");
    a_write_in_conv: assert property (RESULT_WRITE_OUT |-> CONVERTING_OUT && !SAMPLING_OUT)
        else $error("result write outside conversion");
    a_mask_legal: assert property (ACTIVE_CHANNELS_OUT inside {4'h0, 4'h1, 4'h3, 4'hF})
        else $error("illegal channel mask");
    a_aux_first: assert property (CH1_POS_INPUT_OUT inside {3'h0, 3'h3, 3'h7})
        else $error("channel 1 input not 0 or 3");
    a_aux_route: assert property (SIX_INPUTS && CH1_POS_INPUT_OUT != 3'h7 |->
        CH2_POS_INPUT_OUT == CH1_POS_INPUT_OUT + 3'h1 && CH3_POS_INPUT_OUT == CH1_POS_INPUT_OUT + 3'h2)
        else $error("channel 2 or 3 input misrouted");
    a_aux_ground: assert property (AUX_NEG_GROUND_OUT)
        else $error("aux negative input not ground");
    c_irq: cover property (CONV_INTERRUPT_OUT);
    c_four: cover property (ACTIVE_CHANNELS_OUT == 4'hF && RESULT_WRITE_OUT);
    c_start: cover property ($fell(SAMPLING_OUT) ##1 CONVERTING_OUT);
endmodule

//--- tb/adcsq_analog_model.sv
// Analog side model: RC conversion clock and trigger event lines
`timescale 1ns/100ps
module adcsq_analog_model
#(
    parameter int RC_DIV = 3,
    parameter int TRIG_DLY = 20
)
(
    input wire logic clk_in,
    input wire logic sampling_in,
    input wire logic [1:0] trig_sel_in,
    output logic rc_tick_out,
    output logic pin_trig_out,
    output logic timer_trig_out,
    output logic pwm_trig_out
);
    int rc_cnt = 0;
    int smp_cnt = 0;
    initial
    begin
        {rc_tick_out, pin_trig_out, timer_trig_out, pwm_trig_out} = 4'h0;
    end
    // Oscillator runs free, unrelated to divider setting
    always @(posedge clk_in)
    begin
        rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
        rc_tick_out <= (rc_cnt == RC_DIV - 1);
    end
    // One event per sample window, only on the chosen line, so a wrong select stalls
    always @(posedge clk_in)
    begin
        smp_cnt <= sampling_in ? smp_cnt + 1 : 0;
        pin_trig_out <= sampling_in && smp_cnt == TRIG_DLY && trig_sel_in == 2'h1;
        timer_trig_out <= sampling_in && smp_cnt == TRIG_DLY && trig_sel_in == 2'h2;
        pwm_trig_out <= sampling_in && smp_cnt == TRIG_DLY && trig_sel_in == 2'h3;
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for converter sequence control
`timescale 1ns/100ps
module testbench;
    import adcsq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0] scan = 6'h0;
    logic [1:0] tsel = 2'h0;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic hrdy, hresp, rc_t, pin_t, tmr_t, pwm_t, smp, cnv, nneg, agnd, rpos, rneg, rwr, irq;
    logic [2:0] p0, p1, p2, p3;
    logic [2:0] s_pos;
    logic [3:0] act, bidx;
    logic [15:0] wv [4] = '{16'hFFFF, 16'hFF3F, 16'hF9F9, 16'h8D8D};
    logic [15:0] ev [4] = '{16'hE73F, 16'h9F3F, 16'h0101, 16'h8D8D};
    int nch [4] = '{1, 2, 4, 4};
    int msk [4] = '{1, 3, 15, 15};
    int error_cnt = 0;
    int num_checks = 0;
    int nwr = 0, nirq = 0, ncv = 0, nsm = 0;
    int w, v, n, s, e;

    initial
    begin
        forever #20 clk = ~clk;
    end

    adcsq_top u_dut (.MCLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hrdy), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp), .RC_CLOCK_TICK_IN(rc_t), .PIN_TRIGGER_IN(pin_t),
        .TIMER_TRIGGER_IN(tmr_t), .PWM_TRIGGER_IN(pwm_t), .SCAN_SELECT_IN(scan), .SAMPLING_OUT(smp),
        .CONVERTING_OUT(cnv), .CH0_POS_INPUT_OUT(p0), .CH0_NEG_INPUT1_OUT(nneg), .CH1_POS_INPUT_OUT(p1),
        .CH2_POS_INPUT_OUT(p2), .CH3_POS_INPUT_OUT(p3), .AUX_NEG_GROUND_OUT(agnd), .REF_POS_SUPPLY_OUT(rpos),
        .REF_NEG_GROUND_OUT(rneg), .ACTIVE_CHANNELS_OUT(act), .BUFFER_WRITE_INDEX_OUT(bidx),
        .RESULT_WRITE_OUT(rwr), .CONV_INTERRUPT_OUT(irq));

    adcsq_analog_model u_model (.clk_in(clk), .sampling_in(smp), .trig_sel_in(tsel), .rc_tick_out(rc_t),
        .pin_trig_out(pin_t), .timer_trig_out(tmr_t), .pwm_trig_out(pwm_t));

    // Free-running tallies; tests take differences, never reset them mid-edge
    always @(posedge clk)
    begin
        nwr <= nwr + 32'(rwr);
        nirq <= nirq + 32'(irq);
        ncv <= ncv + 32'(cnv);
        nsm <= nsm + 32'(smp);
        if (smp)
            s_pos <= p0;
    end

    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [15:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr_en;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        do @(posedge clk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One sample/convert sequence; on first, then sample, as the module ignores sample while off
    task automatic run(input logic [15:0] c1);
        int w0, v0, n0, s0;
        w0 = nwr;
        v0 = ncv;
        n0 = nirq;
        s0 = nsm;
        bus(1'b1, ADCSQ_OFF_CON1, c1 | 16'h8000);
        bus(1'b1, ADCSQ_OFF_CON1, c1 | 16'h8002);
        if (c1[7:5] == ADCSQ_TRIG_SW)
        begin
            bus(1'b1, ADCSQ_OFF_CON1, c1 | 16'h8000);
            bus(1'b1, ADCSQ_OFF_CON1, c1 | 16'h8000);
            bus(1'b0, ADCSQ_OFF_CON1, 16'h0);
            chk("done in conversion", 32'h0, {31'h0, q[0]});
        end
        for (int i = 0; i < 4000 && !(ncv > v0 && !cnv && !smp); i++)
            @(posedge clk);
        chk("sequence end", 32'h0, {31'h0, cnv || smp});
        repeat (3) @(posedge clk);
        w = nwr - w0;
        v = ncv - v0;
        n = nirq - n0;
        s = nsm - s0;
        bus(1'b0, ADCSQ_OFF_CON1, 16'h0);
        chk("done", 32'h1, {31'h0, q[0]});
        chk("sample bit", 32'h0, {31'h0, q[1]});
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test;
    end

    initial
    begin
        repeat (10) @(posedge clk);
        // Mux outputs leave their reset value at the first edge after release
        chk("ch1 reset", 32'h7, {29'h0, p1});
        rst <= 1'b0;
        @(posedge clk);
        // Offset 0x18 is unmapped and must read zero; status shows the idle state
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, 8'(4 * i), 16'h0);
            chk("reset reg", (i == 5) ? 32'h10 : 32'h0, q);
        end
        chk("okay resp", 32'h0, {31'h0, hresp});
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, 8'(4 + 4 * i), wv[i]);
            bus(1'b0, 8'(4 + 4 * i), 16'h0);
            chk("reg mask", {16'h0, ev[i]}, q);
        end
        bus(1'b1, ADCSQ_OFF_CON2, 16'h0);
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b1, ADCSQ_OFF_CHS0, {8'h0, 1'(i), 2'h0, (i < 6) ? 5'(i) : ADCSQ_SENSOR_CODE});
            bus(1'b1, ADCSQ_OFF_CHS123, 16'(i % 2) * 16'h3);
            bus(1'b0, ADCSQ_OFF_STATUS, 16'h0);
            chk("ch0 pos", (i < 6) ? i : 6, {29'h0, p0});
            chk("ch0 neg", 32'(i % 2), {31'h0, nneg});
            chk("ch1 pos", 3 * (i % 2), {29'h0, p1});
            chk("ch3 pos", 3 * (i % 2) + 2, {29'h0, p3});
            chk("aux ground", 32'h1, {31'h0, agnd});
        end
        $display("test muxes done");
        bus(1'b1, ADCSQ_OFF_CHS0, 16'h0);
        for (int ch = 0; ch < 4; ch++)
        begin
            bus(1'b1, ADCSQ_OFF_CON1, 16'h0);
            bus(1'b1, ADCSQ_OFF_CON3, 16'(ch));
            bus(1'b1, ADCSQ_OFF_CON2, 16'(ch << 8) | 16'h0004);
            for (int k = 0; k < 2; k++)
            begin
                run(16'h0);
                chk("results", 32'(nch[ch]), w);
                chk("mask", 32'(msk[ch]), {28'h0, act});
                // Divider runs free, so the first tick lands up to D cycles early
                e = 13 * (ch + 1) * nch[ch];
                chk("conv len", 32'h1, 32'(v >= e - ch && v <= e));
                chk("irq", 32'(k), n);
                chk("index", k ? 0 : nch[ch], {28'h0, bidx});
            end
        end
        $display("test sequences done");
        bus(1'b1, ADCSQ_OFF_CON2, 16'h0102);
        for (int k = 0; k < 3; k++)
        begin
            run(16'h0);
            bus(1'b0, ADCSQ_OFF_CON2, 16'h0);
            chk("half flag", (k % 2) ? 0 : 1, {31'h0, q[7]});
            chk("index half", (k % 2) ? 0 : 8, {28'h0, bidx});
        end
        bus(1'b1, ADCSQ_OFF_CON1, 16'h0);
        repeat (2) @(posedge clk);
        chk("index off", 32'h0, {28'h0, bidx});
        $display("test split buffer done");
        bus(1'b1, ADCSQ_OFF_CHS0, 16'h0402);
        bus(1'b1, ADCSQ_OFF_CON2, 16'h0001);
        for (int k = 0; k < 3; k++)
        begin
            run(16'h0);
            chk("alt input", (k % 2) ? 4 : 2, {29'h0, s_pos});
        end
        bus(1'b1, ADCSQ_OFF_CON1, 16'h0);
        scan <= 6'h24;
        bus(1'b1, ADCSQ_OFF_CON2, 16'h0400);
        for (int k = 0; k < 3; k++)
        begin
            run(16'h0);
            chk("scan input", (k % 2) ? 5 : 2, {29'h0, s_pos});
        end
        $display("test input select done");
        // Sample time 5, divider 1: counter trigger honours it, event triggers ignore it
        bus(1'b1, ADCSQ_OFF_CON3, 16'h0501);
        run({8'h0, ADCSQ_TRIG_AUTO, 5'h0});
        chk("auto sample", 32'h1, 32'(s >= 8 && s <= 14));
        for (int t = 1; t < 4; t++)
        begin
            tsel <= 2'(t);
            run(16'(t << 5));
            chk("event sample", 32'h1, 32'(s >= 20 && s <= 25));
        end
        bus(1'b1, ADCSQ_OFF_CON3, 16'h803F);
        run(16'h0);
        // Thirteen ticks of a free-running tick every third cycle
        chk("rc conv len", 32'h1, 32'(v >= 37 && v <= 39));
        $display("test triggers and clock done");
        end_of_test;
    end
endmodule

bind adcsq_top adcsq_properties #(.SIX_INPUTS(SIX_INPUTS)) u_props (.*);
